// *** src/bte_pkg.sv ***
package bte_pkg;

  // opcodes
  localparam logic [7:0] OPC_PAGE_Y = 8'h18;
  localparam logic [7:0] OPC_MASK_ZERO_DIR = 8'h13;
  localparam logic [7:0] OPC_MASK_ZERO_IDX = 8'h1f;
  localparam logic [7:0] OPC_MASK_ONE_DIR = 8'h12;
  localparam logic [7:0] OPC_MASK_ONE_IDX = 8'h1e;
  localparam logic [7:0] OPC_SET_BITS_DIR = 8'h14;
  localparam logic [7:0] OPC_SET_BITS_IDX = 8'h1c;
  localparam logic [7:0] OPC_CALL_REL = 8'h8d;
  localparam logic [7:0] OPC_BRANCH_NEVER = 8'h21;
  localparam logic [7:0] OPC_OVF_CLEAR = 8'h28;
  localparam logic [7:0] OPC_UNS_HIGHER = 8'h22;
  localparam logic [7:0] OPC_SGN_GREATER = 8'h2e;
  localparam logic [7:0] OPC_SGN_GREATER_EQ = 8'h2c;
  localparam logic [7:0] OPC_UNS_HIGHER_SAME = 8'h24;
  localparam logic [3:0] OPC_REL_GROUP = 4'h2;

  // bus constants
  localparam logic [15:0] DUMMY_ADDR = 16'hffff;
  localparam logic [7:0] DIRECT_PAGE = 8'h00;
  localparam logic [15:0] BIT_BR_STEP = 16'h0004;
  localparam logic [15:0] BIT_BR_STEP_Y = 16'h0005;
  localparam logic [15:0] REL_STEP = 16'h0002;

  // cycle counts
  localparam logic [3:0] CYC_REL = 4'h3;
  localparam logic [3:0] CYC_CALL = 4'h6;
  localparam logic [3:0] CYC_BIT_DIR = 4'h6;
  localparam logic [3:0] CYC_BIT_X = 4'h7;
  localparam logic [3:0] CYC_BIT_Y = 4'h8;

  // condition code bit positions
  localparam int CCR_N = 3;
  localparam int CCR_Z = 2;
  localparam int CCR_V = 1;
  localparam int CCR_C = 0;

  // register offsets (byte addresses)
  localparam logic [7:0] REG_PC = 8'h00;
  localparam logic [7:0] REG_IX = 8'h04;
  localparam logic [7:0] REG_IY = 8'h08;
  localparam logic [7:0] REG_SP = 8'h0c;
  localparam logic [7:0] REG_CCR = 8'h10;
  localparam logic [7:0] REG_CTRL = 8'h14;
  localparam logic [7:0] REG_STATUS = 8'h18;

  // field positions
  localparam int CTRL_GO = 0;
  localparam int STAT_BUSY = 0;
  localparam int STAT_ILLEGAL = 1;
  localparam int STAT_TAKEN = 2;
  localparam int STAT_OPC_LSB = 8;
  localparam int STAT_CYC_LSB = 16;

  // reset values
  localparam logic [15:0] RST_PC = 16'h0000;
  localparam logic [15:0] RST_IX = 16'h0000;
  localparam logic [15:0] RST_IY = 16'h0000;
  localparam logic [15:0] RST_SP = 16'h00ff;
  localparam logic [7:0] RST_CCR = 8'hd0;

  typedef enum logic [3:0] {
    ST_IDLE, ST_FETCH, ST_PAGE, ST_ADDR, ST_IDXWAIT, ST_OPND, ST_MASK,
    ST_REL, ST_DUMMY, ST_SUB, ST_WRITE, ST_PUSHLO, ST_PUSHHI
  } bte_state_t;

  typedef enum logic [2:0] {
    CL_ILLEGAL, CL_REL, CL_CALL, CL_BIT_BR, CL_SET_BITS
  } bte_class_t;

  typedef enum logic [1:0] {MD_DIR, MD_X, MD_Y} bte_mode_t;

endpackage

// *** src/bte_cond.sv ***
`timescale 1ns/1ps
`default_nettype none
module bte_cond
  import bte_pkg::*;
(
  input wire logic [3:0] cond_code,
  input wire logic [7:0] condition_code_register,
  output logic taken
);
  logic n, z, v, c;

  assign n = condition_code_register[CCR_N];
  assign z = condition_code_register[CCR_Z];
  assign v = condition_code_register[CCR_V];
  assign c = condition_code_register[CCR_C];

  always_comb begin
    unique case (cond_code)
      4'h0: taken = 1'b1;
      4'h1: taken = 1'b0;
      4'h2: taken = ~(c | z);
      4'h3: taken = c | z;
      4'h4: taken = ~c;
      4'h5: taken = c;
      4'h6: taken = ~z;
      4'h7: taken = z;
      4'h8: taken = ~v;
      4'h9: taken = v;
      4'ha: taken = ~n;
      4'hb: taken = n;
      4'hc: taken = ~(n ^ v);
      4'hd: taken = n ^ v;
      4'he: taken = ~(z | (n ^ v));
      4'hf: taken = z | (n ^ v);
    endcase
  end
endmodule
`default_nettype wire

// *** src/bte_bitalu.sv ***
`timescale 1ns/1ps
`default_nettype none
module bte_bitalu #(
  parameter int WIDTH = 8
) (
  input wire logic [WIDTH-1:0] operand,
  input wire logic [WIDTH-1:0] mask,
  input wire logic test_ones,
  output logic cond_met,
  output logic [WIDTH-1:0] set_result
);
  // ones test inverts the operand before the masked zero test
  assign cond_met = ((test_ones ? ~operand : operand) & mask) == '0;
  assign set_result = operand | mask;
endmodule
`default_nettype wire

// *** src/bte_exec.sv ***
// Function
// - masked-zero branch ANDs the memory byte with the mask and branches when the result is zero, leaving flags alone.
// - masked-zero branch is 13 direct (6 cycles), 1F x-indexed (7), 18 1F y-indexed (8), ordered operand, mask, offset, dummy.
// - a taken bit-test branch lands at start plus 4 plus offset, or start plus 5 for the y-indexed form.
// - masked-one branch branches when every masked bit of the memory byte is one.
// - masked-one branch is 12 direct, 1E x-indexed, 18 1E y-indexed, with the same cycles as the zero form.
// - branch never (21) never changes flow and just steps past its two bytes.
// - branch never takes three cycles: opcode, offset, dummy read at FFFF.
// - signed greater, signed greater-equal, unsigned higher and higher-same use the standard flag formulas.
// - set-bits ORs the mask into the addressed byte, leaving other bits unchanged.
// - after set-bits N is result bit 7, Z is set on a zero result, V clears and C holds.
// - set-bits is 14 direct (6), 1C x-indexed (7), 18 1C y-indexed (8), ending with the write.
// - the relative call pushes return low then high, decrementing the stack each time, then branches.
// - the relative call (8D) runs opcode, offset, FFFF dummy, target read, low push at SP, high push at SP-1.
// - overflow-clear branch (28) is taken only when V is zero.
// - every branch offset is a signed byte read after the opcode or after the mask.
//
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module bte_exec
  import bte_pkg::*;
#(
  parameter int AW = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [15:0] mem_addr,
  output logic mem_rw,
  output logic mem_cycle,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  output logic exec_done
);

  bte_state_t state, next_state;
  bte_class_t cls, dec_cls;
  bte_mode_t mode, dec_mode;
  logic [15:0] pc, ix, iy, sp, start_pc, ea, tgt, ret_addr;
  logic [7:0] condition_code_register, opc, addr_byte, opnd, mask, rel, wr_data, rel_byte;
  logic pfx, illegal, last_taken, taken, cond_taken, bit_met, finish, go, wr_en, rd_en;
  logic test_ones, mapped;
  logic [3:0] cyc;
  logic [7:0] set_result;
  logic [7:0] ccr_start;

  assign pready = 1'b1;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~penable & ~pwrite;
  assign mapped = paddr inside {REG_PC, REG_IX, REG_IY, REG_SP, REG_CCR, REG_CTRL, REG_STATUS};
  assign pslverr = psel & penable & ~mapped;
  assign go = wr_en & (paddr == REG_CTRL) & pwdata[CTRL_GO] & (state == ST_IDLE);

  bte_cond u_cond (
    .cond_code(opc[3:0]),
    .condition_code_register(condition_code_register),
    .taken(cond_taken)
  );

  bte_bitalu #(.WIDTH(8)) u_alu (
    .operand(opnd),
    .mask(mask),
    .test_ones(test_ones),
    .cond_met(bit_met),
    .set_result(set_result)
  );

  assign test_ones = (opc == OPC_MASK_ONE_DIR) | (opc == OPC_MASK_ONE_IDX);

  // opcode decode for the fetch and page cycles
  always_comb begin
    dec_cls = CL_ILLEGAL;
    dec_mode = (state == ST_PAGE) ? MD_Y : MD_DIR;
    if (state == ST_PAGE) begin
      unique case (mem_rdata)
        OPC_MASK_ZERO_IDX, OPC_MASK_ONE_IDX: dec_cls = CL_BIT_BR;
        OPC_SET_BITS_IDX: dec_cls = CL_SET_BITS;
        default: dec_cls = CL_ILLEGAL;
      endcase
    end else if (mem_rdata[7:4] == OPC_REL_GROUP) begin
      dec_cls = CL_REL;
    end else begin
      unique case (mem_rdata)
        OPC_MASK_ZERO_DIR, OPC_MASK_ONE_DIR: dec_cls = CL_BIT_BR;
        OPC_MASK_ZERO_IDX, OPC_MASK_ONE_IDX: begin
          dec_cls = CL_BIT_BR;
          dec_mode = MD_X;
        end
        OPC_SET_BITS_DIR: dec_cls = CL_SET_BITS;
        OPC_SET_BITS_IDX: begin
          dec_cls = CL_SET_BITS;
          dec_mode = MD_X;
        end
        OPC_CALL_REL: dec_cls = CL_CALL;
        default: dec_cls = CL_ILLEGAL;
      endcase
    end
  end

  // offset follows the opcode, or the mask for bit-test branches
  assign rel_byte = (cls == CL_BIT_BR) ? rel : addr_byte;
  assign tgt = pc + {{8{rel_byte[7]}}, rel_byte};

  always_comb begin
    unique case (mode)
      MD_DIR: ea = {DIRECT_PAGE, addr_byte};
      MD_X: ea = ix + {8'h00, addr_byte};
      MD_Y: ea = iy + {8'h00, addr_byte};
      default: ea = {DIRECT_PAGE, addr_byte};
    endcase
  end

  always_comb begin
    unique case (cls)
      CL_REL: taken = cond_taken;
      CL_BIT_BR: taken = bit_met;
      CL_CALL: taken = 1'b1;
      default: taken = 1'b0;
    endcase
  end

  assign finish = ((state == ST_DUMMY) & ((cls == CL_REL) | (cls == CL_BIT_BR)))
    | (state == ST_WRITE) | (state == ST_PUSHHI);

  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: if (go) next_state = ST_FETCH;
      ST_FETCH: begin
        if (mem_rdata == OPC_PAGE_Y) next_state = ST_PAGE;
        else if (dec_cls == CL_ILLEGAL) next_state = ST_IDLE;
        else next_state = ST_ADDR;
      end
      ST_PAGE: next_state = (dec_cls == CL_ILLEGAL) ? ST_IDLE : ST_ADDR;
      ST_ADDR: begin
        if ((cls == CL_REL) | (cls == CL_CALL)) next_state = ST_DUMMY;
        else if (mode == MD_DIR) next_state = ST_OPND;
        else next_state = ST_IDXWAIT;
      end
      ST_IDXWAIT: next_state = ST_OPND;
      ST_OPND: next_state = ST_MASK;
      ST_MASK: next_state = (cls == CL_SET_BITS) ? ST_DUMMY : ST_REL;
      ST_REL: next_state = ST_DUMMY;
      ST_DUMMY: begin
        if (cls == CL_CALL) next_state = ST_SUB;
        else if (cls == CL_SET_BITS) next_state = ST_WRITE;
        else next_state = ST_IDLE;
      end
      ST_SUB: next_state = ST_PUSHLO;
      ST_PUSHLO: next_state = ST_PUSHHI;
      ST_PUSHHI: next_state = ST_IDLE;
      ST_WRITE: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) state <= ST_IDLE;
    else state <= next_state;
  end

  // memory bus address and direction
  always_comb begin
    mem_addr = DUMMY_ADDR;
    mem_rw = 1'b1;
    unique case (state)
      ST_FETCH, ST_PAGE, ST_ADDR, ST_MASK, ST_REL: mem_addr = pc;
      ST_IDXWAIT, ST_DUMMY, ST_IDLE: mem_addr = DUMMY_ADDR;
      ST_OPND: mem_addr = ea;
      ST_SUB: mem_addr = tgt;
      ST_WRITE: begin
        mem_addr = ea;
        mem_rw = 1'b0;
      end
      ST_PUSHLO, ST_PUSHHI: begin
        mem_addr = sp;
        mem_rw = 1'b0;
      end
    endcase
  end
  assign mem_cycle = (state != ST_IDLE);
  assign mem_wdata = wr_data;

  // captured instruction bytes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      opc <= 8'h00;
      pfx <= 1'b0;
      cls <= CL_ILLEGAL;
      mode <= MD_DIR;
      addr_byte <= 8'h00;
      opnd <= 8'h00;
      mask <= 8'h00;
      rel <= 8'h00;
    end else begin
      if (state == ST_FETCH) begin
        opc <= mem_rdata;
        pfx <= (mem_rdata == OPC_PAGE_Y);
        cls <= dec_cls;
        mode <= dec_mode;
      end
      if (state == ST_PAGE) begin
        opc <= mem_rdata;
        cls <= dec_cls;
        mode <= dec_mode;
      end
      if (state == ST_ADDR) addr_byte <= mem_rdata;
      if (state == ST_OPND) opnd <= mem_rdata;
      if (state == ST_MASK) mask <= mem_rdata;
      if (state == ST_REL) rel <= mem_rdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) wr_data <= 8'h00;
    else if ((state == ST_DUMMY) & (cls == CL_SET_BITS)) wr_data <= set_result;
    else if (state == ST_SUB) wr_data <= pc[7:0];
    else if (state == ST_PUSHLO) wr_data <= pc[15:8];
  end

  // program counter: software when idle, the sequencer when busy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) pc <= RST_PC;
    else if (wr_en & (paddr == REG_PC) & (state == ST_IDLE)) pc <= pwdata[15:0];
    else if (state inside {ST_FETCH, ST_PAGE, ST_ADDR, ST_MASK, ST_REL}) pc <= pc + 16'h0001;
    else if (finish & taken) pc <= tgt;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) sp <= RST_SP;
    else if (wr_en & (paddr == REG_SP) & (state == ST_IDLE)) sp <= pwdata[15:0];
    else if ((state == ST_PUSHLO) | (state == ST_PUSHHI)) sp <= sp - 16'h0001;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ix <= RST_IX;
      iy <= RST_IY;
    end else if (wr_en & (state == ST_IDLE)) begin
      if (paddr == REG_IX) ix <= pwdata[15:0];
      if (paddr == REG_IY) iy <= pwdata[15:0];
    end
  end

  // only set-bits and a software write to REG_CCR touch the flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) condition_code_register <= RST_CCR;
    else if (wr_en & (paddr == REG_CCR) & (state == ST_IDLE)) condition_code_register <= pwdata[7:0];
    else if (state == ST_WRITE) begin
      condition_code_register[CCR_N] <= wr_data[7];
      condition_code_register[CCR_Z] <= (wr_data == 8'h00);
      condition_code_register[CCR_V] <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc <= 4'h0;
      start_pc <= RST_PC;
      ccr_start <= RST_CCR;
    end else if (go) begin
      cyc <= 4'h1;
      start_pc <= pc;
      ccr_start <= condition_code_register;
    end else if ((state != ST_IDLE) & (next_state != ST_IDLE)) begin
      cyc <= cyc + 4'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_taken <= 1'b0;
      exec_done <= 1'b0;
    end else begin
      exec_done <= finish;
      if (finish) last_taken <= taken;
    end
  end

  // sticky illegal flag, a new event beats a write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) illegal <= 1'b0;
    else if (((state == ST_FETCH) & (mem_rdata != OPC_PAGE_Y) | (state == ST_PAGE))
             & (dec_cls == CL_ILLEGAL)) illegal <= 1'b1;
    else if (wr_en & (paddr == REG_STATUS) & pwdata[STAT_ILLEGAL]) illegal <= 1'b0;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prdata <= 32'h0000_0000;
    else if (rd_en) begin
      unique case (paddr)
        REG_PC: prdata <= {16'h0000, pc};
        REG_IX: prdata <= {16'h0000, ix};
        REG_IY: prdata <= {16'h0000, iy};
        REG_SP: prdata <= {16'h0000, sp};
        REG_CCR: prdata <= {24'h000000, condition_code_register};
        REG_STATUS: begin
          prdata <= 32'h0000_0000;
          prdata[STAT_BUSY] <= (state != ST_IDLE);
          prdata[STAT_ILLEGAL] <= illegal;
          prdata[STAT_TAKEN] <= last_taken;
          prdata[STAT_OPC_LSB +: 8] <= opc;
          prdata[STAT_CYC_LSB +: 4] <= cyc;
        end
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [3:0] cyc_expect;
  assign ret_addr = start_pc + REL_STEP;
  always_comb begin
    unique case (cls)
      CL_REL: cyc_expect = CYC_REL;
      CL_CALL: cyc_expect = CYC_CALL;
      default: cyc_expect = (mode == MD_DIR) ? CYC_BIT_DIR : (mode == MD_X) ? CYC_BIT_X : CYC_BIT_Y;
    endcase
  end

  sequence s_push_lo;
    state == ST_PUSHLO && !mem_rw;
  endsequence
  sequence s_push_hi;
    state == ST_PUSHHI && !mem_rw;
  endsequence

  AST_CYCLE_COUNT: assert property (finish |-> cyc == cyc_expect)
    else $error("instruction length wrong");
  AST_DUMMY_READ: assert property (state == ST_DUMMY |-> mem_addr == DUMMY_ADDR && mem_rw)
    else $error("dummy cycle not a read of ffff");
  AST_BIT_TARGET: assert property (finish && cls == CL_BIT_BR && taken |=>
    pc == $past(start_pc) + (($past(pfx)) ? BIT_BR_STEP_Y : BIT_BR_STEP)
      + {{8{$past(rel[7])}}, $past(rel)})
    else $error("bit branch target wrong");
  AST_BIT_NOFLAG: assert property (finish && cls == CL_BIT_BR |=> condition_code_register == $past(ccr_start))
    else $error("bit branch changed flags");
  AST_NEVER: assert property (finish && opc == OPC_BRANCH_NEVER |=>
    pc == $past(start_pc) + REL_STEP)
    else $error("branch never changed flow");
  AST_SET_RESULT: assert property (state == ST_WRITE |-> mem_wdata == (opnd | mask))
    else $error("set bits result wrong");
  AST_SET_FLAGS: assert property (state == ST_WRITE |=>
    condition_code_register[CCR_N] == $past(mem_wdata[7]) && condition_code_register[CCR_Z] == ($past(mem_wdata) == 8'h00)
    && !condition_code_register[CCR_V] && condition_code_register[CCR_C] == $past(condition_code_register[CCR_C]))
    else $error("set bits flags wrong");
  AST_CALL_PUSH: assert property (s_push_lo |-> mem_wdata == ret_addr[7:0] ##1
    s_push_hi ##0 (mem_addr == $past(mem_addr) - 16'h0001 && mem_wdata == ret_addr[15:8]))
    else $error("call push order wrong");
  AST_OVF_CLEAR: assert property (finish && opc == OPC_OVF_CLEAR |-> taken == !condition_code_register[CCR_V])
    else $error("overflow clear condition wrong");
  AST_UNS_HIGHER: assert property (finish && opc == OPC_UNS_HIGHER |->
    taken == !(condition_code_register[CCR_C] | condition_code_register[CCR_Z]))
    else $error("unsigned higher condition wrong");
  AST_REL_TARGET: assert property (finish && cls == CL_REL && taken |=>
    pc == $past(start_pc) + REL_STEP + {{8{$past(addr_byte[7])}}, $past(addr_byte)})
    else $error("relative target wrong");

endmodule
`default_nettype wire

// *** bench/bte_mem.sv ***
`timescale 1ns/1ps
`default_nettype none
module bte_mem (
  input wire logic pclk,
  input wire logic [15:0] mem_addr,
  input wire logic mem_rw,
  input wire logic mem_cycle,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem [0:65535];
  logic [7:0] last_q = 8'h00;
  // undriven cycles show a pattern that flips every clock
  always_comb begin
    if (mem_cycle && mem_rw) begin
      mem_rdata = mem[mem_addr];
    end else begin
      mem_rdata = ~last_q;
    end
  end
  always @(posedge pclk) begin
    if (mem_cycle && !mem_rw) begin
      mem[mem_addr] <= mem_wdata;
    end
    last_q <= mem_rdata;
  end
endmodule
`default_nettype wire

// *** bench/tb_bit_test_branch_exec.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_bit_test_branch_exec;
  import bte_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic mem_rw, mem_cycle, exec_done;
  logic [7:0] paddr, mem_wdata, mem_rdata;
  logic [31:0] pwdata, prdata;
  logic [15:0] mem_addr;
  logic [24:0] got_q[$];
  logic [24:0] exp_q[$];
  int num_errors = 0;
  int samples_checked = 0;

  bte_exec #(.AW(8)) u_bte_exec (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .mem_addr(mem_addr), .mem_rw(mem_rw),
    .mem_cycle(mem_cycle), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .exec_done(exec_done));
  bte_mem u_bte_mem (.pclk(pclk), .mem_addr(mem_addr), .mem_rw(mem_rw),
    .mem_cycle(mem_cycle), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    if (presetn === 1'b1 && mem_cycle === 1'b1) begin
      got_q.push_back({mem_addr, mem_rw, mem_wdata});
    end
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // read cycles compare address and direction only
  task automatic chk_trace();
    logic [24:0] g, x;
    chk(got_q.size(), exp_q.size(), "bus cycle count");
    for (int i = 0; i < exp_q.size() && i < got_q.size(); i++) begin
      g = got_q[i];
      x = exp_q[i];
      if (x[8]) begin
        g[7:0] = 8'h00;
        x[7:0] = 8'h00;
      end
      chk({7'h00, g}, {7'h00, x}, "bus cycle");
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      chk(32'h0, 32'h1, "apb answer timeout");
      stop_test();
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask

  task automatic e(input logic [15:0] a, input logic rw, input logic [7:0] d);
    exp_q.push_back({a, rw, d});
  endtask

  task automatic run(input logic [15:0] start);
    int n;
    wr(REG_PC, {16'h0, start});
    got_q.delete();
    wr(REG_CTRL, 32'h1);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (exec_done !== 1'b1 && n < 40);
    if (exec_done !== 1'b1) begin
      chk(32'h0, 32'h1, "instruction never finished");
      stop_test();
    end
  endtask

  task automatic test_reset();
    logic [31:0] q;
    logic err;
    rd(REG_PC, q);
    chk(q, 32'h0000, "pc reset");
    rd(REG_SP, q);
    chk(q, 32'h00ff, "sp reset");
    rd(REG_CCR, q);
    chk(q, 32'h00d0, "ccr reset");
    apb(1'b0, 8'h40, 32'h0, q, err);
    chk({31'h0, err}, 32'h1, "unmapped error");
    $display("test reset done");
  endtask

  // kind 0 masked-zero branch, 1 masked-one branch, 2 set bits
  task automatic do_bit(input int kind, input bte_mode_t md, input logic [7:0] opnd,
                        input logic [7:0] mk, input logic [7:0] rr);
    logic [15:0] op, ea, p;
    logic [7:0] opc, res, cc;
    logic [31:0] q;
    logic hit;
    op = 16'h0400;
    p = (md == MD_Y) ? 16'h0001 : 16'h0000;
    ea = (md == MD_DIR) ? 16'h0040 : ((md == MD_X) ? 16'h0210 : 16'h0320);
    case (kind)
      0: opc = (md == MD_DIR) ? OPC_MASK_ZERO_DIR : OPC_MASK_ZERO_IDX;
      1: opc = (md == MD_DIR) ? OPC_MASK_ONE_DIR : OPC_MASK_ONE_IDX;
      default: opc = (md == MD_DIR) ? OPC_SET_BITS_DIR : OPC_SET_BITS_IDX;
    endcase
    u_bte_mem.mem[op] = OPC_PAGE_Y;
    u_bte_mem.mem[op + p] = opc;
    u_bte_mem.mem[op + p + 1] = ea[7:0];
    u_bte_mem.mem[op + p + 2] = mk;
    u_bte_mem.mem[op + p + 3] = rr;
    u_bte_mem.mem[ea] = opnd;
    cc = 8'hdb;
    wr(REG_CCR, {24'h0, cc});
    exp_q.delete();
    e(op, 1'b1, 8'h00);
    if (md == MD_Y) e(op + 1, 1'b1, 8'h00);
    e(op + p + 1, 1'b1, 8'h00);
    if (md != MD_DIR) e(DUMMY_ADDR, 1'b1, 8'h00);
    e(ea, 1'b1, 8'h00);
    e(op + p + 2, 1'b1, 8'h00);
    res = opnd | mk;
    if (kind == 2) begin
      e(DUMMY_ADDR, 1'b1, 8'h00);
      e(ea, 1'b0, res);
    end else begin
      e(op + p + 3, 1'b1, 8'h00);
      e(DUMMY_ADDR, 1'b1, 8'h00);
    end
    run(op);
    chk_trace();
    rd(REG_CCR, q);
    if (kind == 2) begin
      chk({24'h0, u_bte_mem.mem[ea]}, {24'h0, res}, "set bits result");
      chk(q, {24'h0, cc[7:4], res[7], res == 8'h00, 1'b0, cc[0]}, "set bits flags");
    end else begin
      hit = (kind == 0) ? ((opnd & mk) == 8'h00) : ((~opnd & mk) == 8'h00);
      chk(q, {24'h0, cc}, "bit branch flags");
      rd(REG_PC, q);
      chk(q, {16'h0, op + 16'h0004 + p + (hit ? {{8{rr[7]}}, rr} : 16'h0)},
          "bit branch pc");
    end
    $display("test bit op %h mode %0d done", opc, md);
  endtask

  task automatic do_rel(input logic [7:0] opc, input logic [7:0] cc, input logic [7:0] rr);
    logic [15:0] op;
    logic [31:0] q;
    logic hit;
    op = 16'h0600;
    case (opc)
      OPC_OVF_CLEAR: hit = !cc[1];
      OPC_SGN_GREATER: hit = !(cc[2] | (cc[3] ^ cc[1]));
      OPC_SGN_GREATER_EQ: hit = !(cc[3] ^ cc[1]);
      OPC_UNS_HIGHER: hit = !(cc[0] | cc[2]);
      OPC_UNS_HIGHER_SAME: hit = !cc[0];
      default: hit = 1'b0;
    endcase
    u_bte_mem.mem[op] = opc;
    u_bte_mem.mem[op + 1] = rr;
    wr(REG_CCR, {24'h0, cc});
    exp_q.delete();
    e(op, 1'b1, 8'h00);
    e(op + 1, 1'b1, 8'h00);
    e(DUMMY_ADDR, 1'b1, 8'h00);
    run(op);
    chk_trace();
    rd(REG_PC, q);
    chk(q, {16'h0, op + 16'h0002 + (hit ? {{8{rr[7]}}, rr} : 16'h0)},
        "relative pc");
    $display("test relative %h ccr %h done", opc, cc);
  endtask

  task automatic test_call();
    logic [31:0] q;
    u_bte_mem.mem[16'h0700] = OPC_CALL_REL;
    u_bte_mem.mem[16'h0701] = 8'h80;
    wr(REG_SP, 32'h01ff);
    exp_q.delete();
    e(16'h0700, 1'b1, 8'h00);
    e(16'h0701, 1'b1, 8'h00);
    e(DUMMY_ADDR, 1'b1, 8'h00);
    e(16'h0682, 1'b1, 8'h00);
    e(16'h01ff, 1'b0, 8'h02);
    e(16'h01fe, 1'b0, 8'h07);
    run(16'h0700);
    chk_trace();
    rd(REG_PC, q);
    chk(q, 32'h0682, "call target");
    rd(REG_SP, q);
    chk(q, 32'h01fd, "call stack");
    rd(REG_STATUS, q);
    chk(q, 32'h0006_8d04, "call status cycles taken opcode");
    $display("test call done");
  endtask

  // unknown opcode ends after its fetch and sets the sticky flag
  task automatic test_illegal();
    logic [31:0] q;
    u_bte_mem.mem[16'h0800] = 8'h00;
    wr(REG_PC, 32'h0800);
    wr(REG_CTRL, 32'h1);
    rd(REG_STATUS, q);
    chk(q & 32'h3, 32'h2, "illegal flagged");
    wr(REG_STATUS, 32'h2);
    rd(REG_STATUS, q);
    chk(q & 32'h3, 32'h0, "illegal cleared");
    $display("test illegal done");
  endtask

  logic [15:0] rel_tab [14] = '{16'h21d0, 16'h21df, 16'h28d0, 16'h28d2, 16'h2eda, 16'h2ede,
    16'h2ed8, 16'h2cd0, 16'h2cd2, 16'h22d0, 16'h22d1, 16'h22d4, 16'h24d4, 16'h24d1};

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    test_reset();
    wr(REG_IX, 32'h0200);
    wr(REG_IY, 32'h0300);
    do_bit(0, MD_DIR, 8'h5a, 8'ha5, 8'h10);
    do_bit(0, MD_X, 8'h5a, 8'h02, 8'hf0);
    do_bit(0, MD_Y, 8'h00, 8'hff, 8'hf0);
    do_bit(1, MD_DIR, 8'hf3, 8'hf0, 8'h20);
    do_bit(1, MD_X, 8'h7f, 8'h80, 8'h20);
    do_bit(1, MD_Y, 8'hff, 8'h81, 8'h7f);
    do_bit(2, MD_DIR, 8'h00, 8'h00, 8'h00);
    do_bit(2, MD_X, 8'h41, 8'h80, 8'h00);
    do_bit(2, MD_Y, 8'h0f, 8'h30, 8'h00);
    for (int i = 0; i < 14; i++) begin
      do_rel(rel_tab[i][15:8], rel_tab[i][7:0], i[0] ? 8'h80 : 8'h7f);
    end
    test_call();
    test_illegal();
    stop_test();
  end

  initial begin
    repeat (100000) @(posedge pclk);
    num_errors++;
    $display("mismatch at %0t: run did not finish", $time);
    stop_test();
  end
endmodule
`default_nettype wire
